// ===== hdl/dps_pkg.sv
// Package for the dual-port memory host controller.
// Assumes a 10 MHz reference clock and one external dual-port memory port.
package dps_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 9;
  localparam int CLK_PERIOD_NS = 100;
  // Flag update pulse, least time with OE or select released
  localparam int SOP_NS = 12;
  localparam int SOP_CYC = (SOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Access time allowance for array and semaphore reads
  localparam int ACC_NS = 25;
  localparam int ACC_CYC = (ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Write pulse, lengthened to cover driver turn-off plus data setup
  localparam int PWE_NS = 30;
  localparam int PWE_CYC = (PWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SEM_AW = 3'h3;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 9'h000;

  typedef enum logic [1:0] {DPS_RD_ARR, DPS_WR_ARR, DPS_RD_SEM, DPS_WR_SEM} dps_op_t;

  typedef struct packed {
    dps_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dps_req_t;

  typedef struct packed {
    logic ce_n;
    logic sem_n;
    logic rw_n;
    logic oe_n;
    logic [ADDR_W-1:0] addr;
  } dps_pins_t;
endpackage : dps_pkg

// ===== hdl/dps_wait.sv
// Down counter for access and pulse waits.
// Assumes load and count share the host clock.
`timescale 1ns/1ns
module dps_wait (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic load_in,
  input wire logic [3:0] count_in,
  output logic done_out
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (load_in)
    begin
      cnt_nxt = count_in;
    end
    else if (cnt_r != dps_pkg::CNT_ZERO)
    begin
      cnt_nxt = cnt_r - 4'h1;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      cnt_r <= dps_pkg::CNT_ZERO;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

  // Done ignores load, so a caller may reload on done without a comb loop
  assign done_out = (cnt_r == dps_pkg::CNT_ZERO);
endmodule : dps_wait

// ===== hdl/dps_host.sv
// Host controller driving one port of an asynchronous dual-port memory.
// Assumes pin inputs are synchronous to ref_clk_in; the device has no clock.
// Functional notes
// - Read/write stays at read level whenever address lines change.
// - Read/write held at read level throughout every read cycle.
// - Host never drives data while device drives the data pins.
// - With output-enable low, write strobe lengthened for driver turn-off.
// - Continuously-selected address-only reads never used for semaphores.
// - Array select stays high through semaphore write and read.
// - Output-enable or semaphore select released for flag update pulse before readback.
// - During data retention, array select held inactive; an access already under way when retain_in rises still completes.
`timescale 1ns/1ns
module dps_host (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire dps_pkg::dps_req_t req_in,
  input wire logic retain_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [dps_pkg::DATA_W-1:0] rsp_data_out,
  output logic int_pending_out,
  output dps_pkg::dps_pins_t pins_out,
  input wire logic [dps_pkg::DATA_W-1:0] dq_in,
  output logic [dps_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe_n_out,
  input wire logic busy_n_in,
  input wire logic int_n_in
);
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_READ, ST_GAP} dps_state_t;

  dps_state_t state_r, state_nxt;
  dps_pkg::dps_req_t cur_r, cur_nxt;
  dps_pkg::dps_pins_t pins_r, pins_nxt;
  logic [dps_pkg::DATA_W-1:0] dq_r, dq_nxt, rdata_r, rdata_nxt;
  logic dq_oe_n_r, dq_oe_n_nxt, rsp_r, rsp_nxt, int_r, int_nxt;
  logic wait_load;
  logic [3:0] wait_cnt;
  logic wait_done;

  function automatic logic is_write(input dps_pkg::dps_op_t op);
    return (op == dps_pkg::DPS_WR_ARR) || (op == dps_pkg::DPS_WR_SEM);
  endfunction : is_write

  function automatic logic is_sem(input dps_pkg::dps_op_t op);
    return (op == dps_pkg::DPS_RD_SEM) || (op == dps_pkg::DPS_WR_SEM);
  endfunction : is_sem

  function automatic dps_pkg::dps_pins_t idle_pins(input logic [dps_pkg::ADDR_W-1:0] a);
    dps_pkg::dps_pins_t p;
    p.ce_n = 1'b1;
    p.sem_n = 1'b1;
    p.rw_n = 1'b1;
    p.oe_n = 1'b1;
    p.addr = a;
    return p;
  endfunction : idle_pins

  dps_wait u_wait (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .load_in(wait_load),
    .count_in(wait_cnt),
    .done_out(wait_done)
  );

  always_comb
  begin
    state_nxt = state_r;
    cur_nxt = cur_r;
    pins_nxt = pins_r;
    dq_nxt = dq_r;
    dq_oe_n_nxt = dq_oe_n_r;
    rdata_nxt = rdata_r;
    rsp_nxt = 1'b0;
    wait_load = 1'b0;
    wait_cnt = dps_pkg::CNT_ZERO;
    unique case (state_r)
      ST_IDLE:
      begin
        // Retention keeps both selects high
        if (req_valid_in && !retain_in)
        begin
          cur_nxt = req_in;
          // Address moves only with all strobes idle
          pins_nxt = idle_pins(req_in.addr);
          if (is_sem(req_in.op))
          begin
            // Only the latch index is meaningful
            pins_nxt.addr = {{(dps_pkg::ADDR_W-3){1'b0}}, req_in.addr[dps_pkg::SEM_AW-1:0]};
          end
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        // Array select stays high for semaphore ops
        pins_nxt.ce_n = is_sem(cur_r.op);
        pins_nxt.sem_n = !is_sem(cur_r.op);
        if (is_write(cur_r.op))
        begin
          // Select and write-enable together: device keeps outputs off
          pins_nxt.rw_n = 1'b0;
          dq_nxt = is_sem(cur_r.op) ? {{(dps_pkg::DATA_W-1){1'b0}}, cur_r.wdata[0]} : cur_r.wdata;
          // Output-enable kept high, so the device never drives here
          dq_oe_n_nxt = 1'b0;
          wait_load = 1'b1;
          wait_cnt = 4'(dps_pkg::PWE_CYC);
          state_nxt = ST_STROBE;
        end
        else
        begin
          // Read level held, each semaphore read reselects
          pins_nxt.oe_n = 1'b0;
          wait_load = 1'b1;
          wait_cnt = 4'(dps_pkg::ACC_CYC);
          state_nxt = ST_READ;
        end
      end
      ST_STROBE:
      begin
        // Slave write waits while busy is low
        if (wait_done && busy_n_in)
        begin
          // Write-enable released first ends the write
          pins_nxt.rw_n = 1'b1;
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        pins_nxt.ce_n = 1'b1;
        pins_nxt.sem_n = 1'b1;
        dq_oe_n_nxt = 1'b1;
        rsp_nxt = 1'b1;
        wait_load = 1'b1;
        wait_cnt = 4'(dps_pkg::SOP_CYC);
        state_nxt = ST_GAP;
      end
      ST_READ:
      begin
        // Data sampled only after busy is released
        if (wait_done && busy_n_in)
        begin
          // Captured once; later latch changes do not disturb it
          rdata_nxt = dq_in;
          rsp_nxt = 1'b1;
          pins_nxt = idle_pins(pins_r.addr);
          wait_load = 1'b1;
          wait_cnt = 4'(dps_pkg::SOP_CYC);
          state_nxt = ST_GAP;
        end
      end
      ST_GAP:
      begin
        // Selects and output-enable high for the flag update pulse
        if (wait_done)
        begin
          state_nxt = ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Mailbox flag mirrored from the device
  always_comb
  begin
    int_nxt = !int_n_in;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      state_r <= ST_IDLE;
      cur_r <= '0;
      pins_r <= {1'b1, 1'b1, 1'b1, 1'b1, {dps_pkg::ADDR_W{1'b0}}};
      dq_r <= dps_pkg::DATA_ZERO;
      dq_oe_n_r <= 1'b1;
      rdata_r <= dps_pkg::DATA_ZERO;
      rsp_r <= 1'b0;
      int_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      pins_r <= pins_nxt;
      dq_r <= dq_nxt;
      dq_oe_n_r <= dq_oe_n_nxt;
      rdata_r <= rdata_nxt;
      rsp_r <= rsp_nxt;
      int_r <= int_nxt;
    end
  end

  assign req_ready_out = (state_r == ST_IDLE) && !retain_in;
  assign rsp_valid_out = rsp_r;
  assign rsp_data_out = rdata_r;
  assign int_pending_out = int_r;
  assign pins_out = pins_r;
  assign dq_out = dq_r;
  assign dq_oe_n_out = dq_oe_n_r;

  a_addr_rw_stable: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (pins_out.addr != $past(pins_out.addr)) |-> pins_out.rw_n)
    else $error("address changed with write-enable low");

  a_no_bus_fight: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !dq_oe_n_out |-> pins_out.oe_n)
    else $error("host drives data while output-enable low");

  a_read_level: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !pins_out.oe_n |-> pins_out.rw_n)
    else $error("write-enable low during a read");

  a_sem_ce_high: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !pins_out.sem_n |-> pins_out.ce_n)
    else $error("array select low with semaphore select");

  a_retain_idle: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (retain_in && state_r == ST_IDLE) |=> pins_out.ce_n && pins_out.sem_n)
    else $error("select active during retention");

  sequence s_write_end;
    !pins_out.rw_n ##1 pins_out.rw_n;
  endsequence

  a_write_gap: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    s_write_end |=> (pins_out.ce_n && pins_out.sem_n && pins_out.oe_n)[*2])
    else $error("no flag update pulse after write");

  a_slave_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state_r == ST_STROBE && !busy_n_in) |=> !pins_out.rw_n)
    else $error("write ended while busy");

  a_sem_addr: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !pins_out.sem_n |-> (pins_out.addr[dps_pkg::ADDR_W-1:3] == '0))
    else $error("upper address bits set on semaphore access");

  a_rsp_pulse: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    rsp_valid_out |=> !rsp_valid_out && $stable(rsp_data_out))
    else $error("response not a one-cycle pulse");
endmodule : dps_host

// ===== verif/dps_dev_model.sv
// Behavioural port of the dual-port memory: array, semaphores, mailbox flag.
// Assumes host pins change on one clock; far port is driven by the bench.
`timescale 1ns/1ns
module dps_dev_model (
  input wire dps_pkg::dps_pins_t pins_in,
  input wire logic [8:0] wd_in,
  input wire logic busy_n_in,
  input wire logic [7:0] far_req_in,
  input wire logic far_mail_in,
  output logic [8:0] rd_out,
  output logic int_n_out
);
  logic [8:0] mem [0:32767];
  logic [7:0] near_req = 8'h00;
  logic [7:0] near_own = 8'h00;
  logic [7:0] far_own = 8'h00;
  logic [8:0] sem_q = 9'h1FF;
  logic [8:0] held = 9'h000;
  logic sem_sel, wr_on, rd_on;
  assign sem_sel = pins_in.ce_n && !pins_in.sem_n;
  assign wr_on = !pins_in.rw_n && (!pins_in.ce_n || !pins_in.sem_n);
  assign rd_on = !pins_in.oe_n && pins_in.rw_n && (pins_in.ce_n != pins_in.sem_n);
  initial int_n_out = 1'b1;
  // Holder keeps a latch; a waiting request takes it on release
  task automatic settle;
    near_own = near_own & near_req;
    far_own = far_own & far_req_in;
    near_own = near_own | (near_req & ~far_own);
    far_own = far_own | (far_req_in & ~near_own);
  endtask : settle
  always @(far_req_in) settle();
  always @(posedge far_mail_in) int_n_out = 1'b0;
  // Slave write is dropped while busy holds it off
  always @(negedge wr_on)
  begin
    if (busy_n_in && sem_sel)
    begin
      near_req[pins_in.addr[2:0]] = !wd_in[0];
      settle();
    end
    else if (busy_n_in)
      mem[pins_in.addr] = wd_in;
  end
  always @(posedge rd_on)
  begin
    sem_q = {9{~near_own[pins_in.addr[2:0]]}};
    if (!pins_in.ce_n && pins_in.addr == 15'h7FFE && busy_n_in)
      int_n_out = 1'b1;
  end
  // Off lines show the inverse so a stale sample cannot match
  assign rd_out = (rd_on && busy_n_in) ? (sem_sel ? sem_q : mem[pins_in.addr]) : ~held;
  always @(rd_out)
    if (rd_on && busy_n_in)
      held = rd_out;
endmodule : dps_dev_model

// ===== verif/testbench.sv
// Self-checking bench for the dual-port memory host controller.
// Assumes the behavioural device model on the pin side.
`timescale 1ns/1ns
module testbench;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic req_valid = 1'b0;
  dps_pkg::dps_req_t req = '0;
  logic retain = 1'b0;
  logic busy_n = 1'b1;
  logic far_mail = 1'b0;
  logic [7:0] far_req = 8'h00;
  logic ready, rsp_v, int_p, dq_oe_n, int_n;
  logic [8:0] rsp_d, host_dq, dev_dq, bus, q;
  dps_pkg::dps_pins_t pins;
  int mismatches = 0;
  int comparisons = 0;
  int lat;
  always #50 ref_clk_in = ~ref_clk_in;
  assign bus = dq_oe_n ? dev_dq : host_dq;
  dps_host dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .req_valid_in(req_valid), .req_in(req),
    .retain_in(retain), .req_ready_out(ready), .rsp_valid_out(rsp_v), .rsp_data_out(rsp_d),
    .int_pending_out(int_p), .pins_out(pins), .dq_in(bus), .dq_out(host_dq), .dq_oe_n_out(dq_oe_n),
    .busy_n_in(busy_n), .int_n_in(int_n));
  dps_dev_model dev_u (.pins_in(pins), .wd_in(bus), .busy_n_in(busy_n), .far_req_in(far_req),
    .far_mail_in(far_mail), .rd_out(dev_dq), .int_n_out(int_n));
  task automatic final_report;
    if (mismatches == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask : chk_val
  task automatic chk_cnt(input int got, input int exp);
    comparisons++;
    if (got != exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask : chk_cnt
  task automatic do_req(input dps_pkg::dps_op_t op, input logic [14:0] a, input logic [8:0] d);
    int n;
    @(negedge ref_clk_in);
    req_valid = 1'b1;
    req = '{op, a, d};
    n = 0;
    while (ready !== 1'b1 && n < 50)
    begin
      @(negedge ref_clk_in);
      n++;
    end
    @(posedge ref_clk_in);
    lat = 0;
    while (lat < 60)
    begin
      @(negedge ref_clk_in);
      req_valid = 1'b0;
      if (rsp_v === 1'b1)
        break;
      lat++;
    end
    q = rsp_d;
    chk_cnt(lat < 60, 1);
  endtask : do_req
  task automatic t_array;
    do_req(dps_pkg::DPS_WR_ARR, 15'h7FFD, 9'h1A5);
    chk_cnt(lat, 4);
    do_req(dps_pkg::DPS_WR_ARR, 15'h0002, 9'h05A);
    do_req(dps_pkg::DPS_RD_ARR, 15'h7FFD, 9'h000);
    chk_val(q, 9'h1A5);
    chk_cnt(lat, 3);
    do_req(dps_pkg::DPS_RD_ARR, 15'h0002, 9'h000);
    chk_val(q, 9'h05A);
  endtask : t_array
  task automatic t_sem;
    do_req(dps_pkg::DPS_RD_SEM, 15'h7FF2, 9'h000);
    chk_val(q, 9'h1FF);
    do_req(dps_pkg::DPS_WR_SEM, 15'h4005, 9'h1FE);
    do_req(dps_pkg::DPS_RD_SEM, 15'h0005, 9'h000);
    chk_val(q, 9'h000);
    far_req[5] = 1'b1;
    do_req(dps_pkg::DPS_RD_SEM, 15'h0005, 9'h000);
    chk_val(q, 9'h000);
    do_req(dps_pkg::DPS_WR_SEM, 15'h0005, 9'h001);
    do_req(dps_pkg::DPS_RD_SEM, 15'h0005, 9'h000);
    chk_val(q, 9'h1FF);
    far_req[5] = 1'b0;
  endtask : t_sem
  task automatic t_busy(input dps_pkg::dps_op_t op, input int base);
    fork
      begin
        @(negedge ref_clk_in);
        busy_n = 1'b0;
        repeat (6) @(negedge ref_clk_in);
        busy_n = 1'b1;
      end
      do_req(op, 15'h0100, 9'h0C3);
    join
    chk_cnt(lat > base, 1);
    // Data taken at busy release must already be the stored word
    if (op == dps_pkg::DPS_RD_ARR)
      chk_val(q, 9'h0C3);
    do_req(dps_pkg::DPS_RD_ARR, 15'h0100, 9'h000);
    chk_val(q, 9'h0C3);
  endtask : t_busy
  task automatic t_mail;
    @(negedge ref_clk_in);
    far_mail = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    chk_val({8'h00, int_p}, 9'h001);
    do_req(dps_pkg::DPS_RD_ARR, 15'h7FFF, 9'h000);
    chk_val({8'h00, int_p}, 9'h001);
    do_req(dps_pkg::DPS_RD_ARR, 15'h7FFE, 9'h000);
    far_mail = 1'b0;
    repeat (2) @(negedge ref_clk_in);
    chk_val({8'h00, int_p}, 9'h000);
  endtask : t_mail
  task automatic t_retain;
    @(negedge ref_clk_in);
    retain = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    chk_val({8'h00, ready}, 9'h000);
    chk_val({7'h00, pins.ce_n, pins.sem_n}, 9'h003);
    retain = 1'b0;
  endtask : t_retain
  initial
  begin
    repeat (10) @(negedge ref_clk_in);
    rst_in = 1'b0;
    t_array();
    t_sem();
    t_busy(dps_pkg::DPS_WR_ARR, 4);
    t_busy(dps_pkg::DPS_RD_ARR, 3);
    t_mail();
    t_retain();
    final_report();
  end
  initial
  begin
    #2000000;
    mismatches++;
    final_report();
  end
endmodule : testbench
